// ==== tsch_pkg.sv ====
/*
 * Constants, field positions and carrier types for the chunked-transfer and
 * suspend command handler. Assumes one 125 MHz clock and an APB register port.
 */
// How it works
// - TLV length is one byte up to 0x7F, or 0x81 plus a byte for 128-255.
// - Transfer data must use tag 0x80; all other tags are reserved.
// - Successful transfer answers with status byte one 0x92, details in byte two.
// - Byte two bits 8-6 reserved zero; bit 5 set asks for a re-send.
// - Byte two bit 4 is set while a proactive message is pending.
// - Byte two bits 3-2 carry the session the pending block answers.
// - Byte two bit 1 set means more blocks pending; terminal must fetch them.
// - Returning 6A84 aborts the current transfer session.
// - Card may return response data before the terminal sent all its data.
// - Response data is wrapped in TLV with the command's tag and format.
// - Suspend first parameter: bit 1 zero suspend, one resume; rest zero. The handler refuses resume (bit 1 one) with 6A86.
// - Suspend saves the complete card status to non-volatile memory.
// - Suspend refused with 6985 while proactive, BIP or secure channel busy.
// - Suspend refused with 9864 when requested minimum duration is too long.
// - Suspend makes an 8-byte token and a negotiated duration within bounds.
// - After a good suspend the card never answers with 91 XX.
// - Suspend: parameters zero, length 4 in, 10 out, fixed byte layout.
// - Durations are a unit byte (s, min, h, days, 10 days) then a count.
// - Up to four interleaved sessions, each with its own block state.
package tsch_pkg;
	localparam logic [7:0] OFF_CTRL      = 8'h00;
	localparam logic [7:0] OFF_LEN       = 8'h04;
	localparam logic [7:0] OFF_CDATA     = 8'h08;
	localparam logic [7:0] OFF_STATUS    = 8'h0C;
	localparam logic [7:0] OFF_RDATA     = 8'h10;
	localparam logic [7:0] OFF_COND      = 8'h14;
	localparam logic [7:0] OFF_STAGE     = 8'h18;
	localparam logic [7:0] OFF_STAGE_CTL = 8'h1C;
	localparam logic [7:0] OFF_TOKEN_LO  = 8'h20;
	localparam logic [7:0] OFF_TOKEN_HI  = 8'h24;
	localparam logic [7:0] OFF_NEGO      = 8'h28;

	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_KIND_BIT  = 1;
	localparam int CTRL_P1_LSB    = 8;
	localparam int CTRL_P2_LSB    = 16;
	localparam int LEN_LE_LSB     = 8;
	localparam int STAGE_VALID_BIT = 8;
	localparam int STATUS_BUSY_BIT = 16;

	localparam int P1_SESS_LSB  = 6;
	localparam int P1_DATA_BIT  = 2;
	localparam int P1_ABORT_BIT = 1;
	localparam int P1_RETX_BIT  = 0;

	localparam int BUF_DEPTH = 16;
	localparam int RSP_DEPTH = 18;
	localparam int NSESS     = 4;
	localparam int TOKEN_BYTES = 8;

	localparam logic [7:0]  TAG_SECURE    = 8'h80;
	localparam logic [7:0]  LEN_SHORT_MAX = 8'h7F;
	localparam logic [7:0]  LEN_LONG      = 8'h81;
	localparam logic [7:0]  LEN_LONG_MIN  = 8'h80;
	localparam logic [7:0]  SW1_ONGOING   = 8'h92;
	localparam logic [7:0]  SW1_PROACTIVE = 8'h91;
	localparam logic [15:0] SW_OK         = 16'h9000;
	localparam logic [15:0] SW_NOMEM      = 16'h6A84;
	localparam logic [15:0] SW_COND       = 16'h6985;
	localparam logic [15:0] SW_DURATION   = 16'h9864;
	localparam logic [15:0] SW_BAD_DATA   = 16'h6A80;
	localparam logic [15:0] SW_BAD_LEN    = 16'h6700;
	localparam logic [15:0] SW_BAD_P1     = 16'h6A86;
	localparam logic [7:0]  SUS_LC        = 8'h04;
	localparam logic [7:0]  SUS_LE        = 8'h0A;
	localparam logic [4:0]  SUS_RSP_LEN   = 5'h0A;

	localparam logic [7:0]  UNIT_MAX      = 8'h04;
	localparam logic [7:0]  CARD_LIM_UNIT = 8'h03;
	localparam logic [7:0]  CARD_LIM_CNT  = 8'h1E;
	localparam logic [63:0] LFSR_SEED     = 64'h5A5A_C3C3_0F0F_9696;
	localparam logic [63:0] LFSR_TAPS     = 64'hD800_0000_0000_0000;

	typedef struct packed {
		logic [7:0] sw1;
		logic [7:0] sw2;
	} tsch_sw_t;

	typedef struct packed {
		logic [7:0] unit;
		logic [7:0] count;
	} tsch_dur_t;

	typedef struct packed {
		logic internal_reject;
		logic mem_full;
		logic resend_req;
		logic sc_in_use;
		logic bip_open;
		logic pro_active;
		logic pro_pending;
	} tsch_cond_t;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_SAVE} tsch_state_t;
endpackage

// ==== tsch_handler.sv ====
/*
 * Command handler for the chunked transfer command and the suspend command,
 * reached over APB. Software loads a command, starts it, reads status words
 * and response bytes. Assumes synchronous inputs and a single clock domain.
 */
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tsch_handler (
	// clock and reset
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// non-volatile status save
	output logic                      nvm_save,
	output logic      [63:0]          nvm_token
);
	import tsch_pkg::*;

	tsch_state_t state;
	tsch_cond_t  cond;
	tsch_sw_t    sw;
	tsch_sw_t    e_sw;
	tsch_dur_t   nego;
	tsch_dur_t   e_nego;
	logic [7:0]  p1;
	logic [7:0]  p2;
	logic        kind_sus;
	logic [7:0]  lc;
	logic [7:0]  le;
	logic [7:0]  cmd_buf [BUF_DEPTH];
	logic [4:0]  cmd_idx;
	logic [7:0]  stage_buf [BUF_DEPTH];
	logic [4:0]  stage_cnt;
	logic [1:0]  stage_sess;
	logic        stage_valid;
	logic [7:0]  rsp_buf [RSP_DEPTH];
	logic [4:0]  rsp_len;
	logic [4:0]  rd_ptr;
	logic [NSESS-1:0] sess_active;
	logic [7:0]  sess_tag [NSESS];
	logic [63:0] lfsr;
	logic [1:0]  sess;
	logic        e_abort;
	logic        e_open;
	logic        e_deliver;
	logic        e_resend;
	logic        e_save;
	logic        e_more;
	logic        tlv_ok;
	logic [7:0]  tlv_plen;
	logic [8:0]  tlv_total;
	logic [31:0] min_secs;
	logic [31:0] max_secs;
	logic [31:0] lim_secs;
	logic        acc;
	logic        wr;
	logic        rd;
	logic        busy;
	logic        addr_ok;

	// duration in seconds; widest case fits in 32 bits
	function automatic logic [31:0] dur_secs(input logic [7:0] unit, input logic [7:0] count);
		logic [31:0] f;
		f = 32'h0000_0001;
		case (unit)
			8'h00: f = 32'h0000_0001;
			8'h01: f = 32'h0000_003C;
			8'h02: f = 32'h0000_0E10;
			8'h03: f = 32'h0001_5180;
			8'h04: f = 32'h000D_2F00;
			default: f = 32'h0000_0000;
		endcase
		return f * {24'h00_0000, count};
	endfunction

	function automatic logic map_ok(input logic [7:0] a);
		return a == OFF_CTRL || a == OFF_LEN || a == OFF_CDATA || a == OFF_STATUS ||
			a == OFF_RDATA || a == OFF_COND || a == OFF_STAGE || a == OFF_STAGE_CTL ||
			a == OFF_TOKEN_LO || a == OFF_TOKEN_HI || a == OFF_NEGO;
	endfunction

	assign acc     = psel && penable;
	assign addr_ok = map_ok(paddr);
	assign wr      = acc && pwrite && addr_ok;
	assign rd      = acc && !pwrite && addr_ok;
	assign busy    = state != ST_IDLE;
	assign pready  = 1'b1;
	assign pslverr = acc && !addr_ok;
	assign sess    = p1[P1_SESS_LSB +: 2];

	// tlv header check over the command bytes
	always_comb begin
		tlv_ok   = 1'b0;
		tlv_plen = 8'h00;
		tlv_total = 9'h000;
		if (cmd_buf[1] <= LEN_SHORT_MAX) begin
			tlv_plen  = cmd_buf[1];
			tlv_total = {1'b0, tlv_plen} + 9'h002;
			tlv_ok    = lc >= 8'h02;
		end else if (cmd_buf[1] == LEN_LONG && cmd_buf[2] >= LEN_LONG_MIN) begin
			tlv_plen  = cmd_buf[2];
			tlv_total = {1'b0, tlv_plen} + 9'h003;
			tlv_ok    = lc >= 8'h03;
		end
		// reserved tag, tag change in a session or length mismatch is refused
		if (cmd_buf[0] != TAG_SECURE)
			tlv_ok = 1'b0;
		if (sess_active[sess] && cmd_buf[0] != sess_tag[sess])
			tlv_ok = 1'b0;
		if (tlv_total != {1'b0, lc})
			tlv_ok = 1'b0;
	end

	assign min_secs = dur_secs(cmd_buf[0], cmd_buf[1]);
	assign max_secs = dur_secs(cmd_buf[2], cmd_buf[3]);
	assign lim_secs = dur_secs(CARD_LIM_UNIT, CARD_LIM_CNT);

	// command execution decision
	always_comb begin
		e_sw      = SW_OK;
		e_abort   = 1'b0;
		e_open    = 1'b0;
		e_deliver = 1'b0;
		e_resend  = 1'b0;
		e_save    = 1'b0;
		e_more    = 1'b0;
		e_nego    = {cmd_buf[2], cmd_buf[3]};
		if (!kind_sus) begin
			if (p1[P1_ABORT_BIT]) begin
				e_abort = 1'b1;
			end else if (p1[P1_DATA_BIT]) begin
				if (p1[P1_RETX_BIT] || p1[5:3] != 3'b000)
					e_sw = SW_BAD_P1;
				else if (!tlv_ok)
					e_sw = SW_BAD_DATA;
				else if (cond.mem_full) begin
					e_sw    = SW_NOMEM;
					e_abort = 1'b1;
				end else
					e_open = 1'b1;
			end else if (p1[P1_RETX_BIT]) begin
				e_resend = 1'b1;
			end else if (stage_valid && stage_sess == sess) begin
				e_deliver = 1'b1;
			end
			if (e_sw == SW_OK && !e_abort) begin
				// pending data of any session is flagged, even mid-upload
				e_more = stage_valid && !e_deliver;
				e_sw.sw1 = SW1_ONGOING;
				e_sw.sw2 = {3'b000, cond.resend_req && p1[P1_DATA_BIT], cond.pro_pending,
					e_more ? stage_sess : sess, e_more};
			end
		end else begin
			if (p1[7:1] != 7'h00 || p1[0] || p2 != 8'h00)
				e_sw = SW_BAD_P1;
			else if (lc != SUS_LC || le != SUS_LE)
				e_sw = SW_BAD_LEN;
			else if (cmd_buf[0] > UNIT_MAX || cmd_buf[2] > UNIT_MAX || min_secs > max_secs)
				e_sw = SW_BAD_DATA;
			else if (cond.pro_active || cond.bip_open || cond.sc_in_use || cond.internal_reject)
				e_sw = SW_COND;
			else if (min_secs > lim_secs)
				e_sw = SW_DURATION;
			else begin
				e_save = 1'b1;
				if (max_secs > lim_secs)
					e_nego = {CARD_LIM_UNIT, CARD_LIM_CNT};
			end
		end
	end

	// sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state <= ST_IDLE;
		else begin
			case (state)
				ST_IDLE: if (wr && paddr == OFF_CTRL && pwdata[CTRL_START_BIT])
					state <= ST_EXEC;
				ST_EXEC: state <= e_save ? ST_SAVE : ST_IDLE;
				ST_SAVE: state <= ST_IDLE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// command header and data bytes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1       <= 8'h00;
			p2       <= 8'h00;
			kind_sus <= 1'b0;
			lc       <= 8'h00;
			le       <= 8'h00;
			cmd_idx  <= 5'h00;
			for (int i = 0; i < BUF_DEPTH; i++)
				cmd_buf[i] <= 8'h00;
		end else if (wr && !busy) begin
			if (paddr == OFF_CTRL) begin
				kind_sus <= pwdata[CTRL_KIND_BIT];
				p1       <= pwdata[CTRL_P1_LSB +: 8];
				p2       <= pwdata[CTRL_P2_LSB +: 8];
			end
			if (paddr == OFF_LEN) begin
				lc      <= pwdata[7:0];
				le      <= pwdata[LEN_LE_LSB +: 8];
				cmd_idx <= 5'h00;
			end
			if (paddr == OFF_CDATA && cmd_idx < 5'(BUF_DEPTH)) begin
				cmd_buf[cmd_idx[3:0]] <= pwdata[7:0];
				cmd_idx <= cmd_idx + 5'h01;
			end
		end
	end

	// card conditions seen by the handler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cond <= '0;
		else if (wr && paddr == OFF_COND)
			cond <= pwdata[6:0];
	end

	// staged response payload; software load is ignored while busy, so delivery clear wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage_cnt   <= 5'h00;
			stage_sess  <= 2'b00;
			stage_valid <= 1'b0;
			for (int i = 0; i < BUF_DEPTH; i++)
				stage_buf[i] <= 8'h00;
		end else begin
			if (state == ST_EXEC && e_deliver) begin
				stage_valid <= 1'b0;
				stage_cnt   <= 5'h00;
			end
			if (wr && !busy && paddr == OFF_STAGE && stage_cnt < 5'(BUF_DEPTH)) begin
				stage_buf[stage_cnt[3:0]] <= pwdata[7:0];
				stage_cnt <= stage_cnt + 5'h01;
			end
			if (wr && !busy && paddr == OFF_STAGE_CTL) begin
				stage_sess  <= pwdata[1:0];
				stage_valid <= pwdata[STAGE_VALID_BIT];
				if (!pwdata[STAGE_VALID_BIT])
					stage_cnt <= 5'h00;
			end
		end
	end

	// per-session block state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sess_active <= '0;
			for (int i = 0; i < NSESS; i++)
				sess_tag[i] <= TAG_SECURE;
		end else if (state == ST_EXEC && !kind_sus) begin
			if (e_abort)
				sess_active[sess] <= 1'b0;
			else if (e_open && !sess_active[sess]) begin
				sess_active[sess] <= 1'b1;
				sess_tag[sess]    <= cmd_buf[0];
			end
		end
	end

	// status words
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sw <= SW_OK;
		else if (state == ST_EXEC)
			sw <= e_sw;
	end

	// response buffer and read pointer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_len <= 5'h00;
			rd_ptr  <= 5'h00;
			for (int i = 0; i < RSP_DEPTH; i++)
				rsp_buf[i] <= 8'h00;
		end else if (state == ST_EXEC) begin
			rd_ptr <= 5'h00;
			if (e_deliver) begin
				// payload never exceeds the short length form here
				rsp_buf[0] <= sess_active[sess] ? sess_tag[sess] : TAG_SECURE;
				rsp_buf[1] <= {3'b000, stage_cnt};
				for (int i = 0; i < BUF_DEPTH; i++)
					rsp_buf[i + 2] <= stage_buf[i];
				rsp_len <= stage_cnt + 5'h02;
			end else if (e_save) begin
				rsp_buf[0] <= e_nego.unit;
				rsp_buf[1] <= e_nego.count;
				for (int i = 0; i < TOKEN_BYTES; i++)
					rsp_buf[i + 2] <= lfsr[63 - 8 * i -: 8];
				rsp_len <= SUS_RSP_LEN;
			end else if (!e_resend)
				rsp_len <= 5'h00;
		end else if (rd && paddr == OFF_RDATA && rd_ptr < rsp_len)
			rd_ptr <= rd_ptr + 5'h01;
	end

	// token source, free running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			lfsr <= LFSR_SEED;
		else
			lfsr <= {1'b0, lfsr[63:1]} ^ (lfsr[0] ? LFSR_TAPS : 64'h0000_0000_0000_0000);
	end

	// saved status: token, negotiated duration, save strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvm_token <= 64'h0000_0000_0000_0000;
			nego      <= '0;
			nvm_save  <= 1'b0;
		end else begin
			nvm_save <= state == ST_EXEC && e_save;
			if (state == ST_EXEC && e_save) begin
				nvm_token <= lfsr;
				nego      <= e_nego;
			end
		end
	end

	// read data captured in the setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (psel && !penable && !pwrite) begin
			case (paddr)
				OFF_CTRL:      prdata <= {8'h00, p2, p1, 6'h00, kind_sus, 1'b0};
				OFF_LEN:       prdata <= {16'h0000, le, lc};
				OFF_STATUS:    prdata <= {15'h0000, busy, sw};
				OFF_RDATA:     prdata <= {24'h00_0000, rd_ptr < rsp_len ? rsp_buf[rd_ptr] : 8'h00};
				OFF_COND:      prdata <= {25'h000_0000, cond};
				OFF_STAGE_CTL: prdata <= {sess_active, 7'h00, stage_cnt, 7'h00, stage_valid,
					6'h00, stage_sess};
				OFF_TOKEN_LO:  prdata <= nvm_token[31:0];
				OFF_TOKEN_HI:  prdata <= nvm_token[63:32];
				OFF_NEGO:      prdata <= {11'h000, rsp_len, nego};
				default:       prdata <= 32'h0000_0000;
			endcase
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic xfer_good;
	assign xfer_good = state == ST_EXEC && !kind_sus && e_sw.sw1 == SW1_ONGOING;

	a_tlv_len_form: assert property (state == ST_EXEC && !kind_sus && e_open |->
		cmd_buf[1] <= LEN_SHORT_MAX || cmd_buf[1] == LEN_LONG)
		else $error("accepted tlv with bad length form");
	a_tag_secure: assert property (state == ST_EXEC && e_open |-> cmd_buf[0] == TAG_SECURE)
		else $error("accepted reserved tag");
	a_ongoing_sw: assert property (state == ST_EXEC && !kind_sus && e_open |=>
		sw.sw1 == SW1_ONGOING && state == ST_IDLE)
		else $error("transfer not answered 92");
	a_rfu_zero: assert property (sw.sw1 == SW1_ONGOING |-> sw.sw2[7:5] == 3'b000)
		else $error("reserved status bits set");
	a_pro_bit: assert property (xfer_good |=> sw.sw2[3] == $past(cond.pro_pending))
		else $error("proactive bit wrong");
	a_sess_bits: assert property (xfer_good && !stage_valid |=> sw.sw2[2:1] == $past(sess))
		else $error("session bits wrong");
	a_more_bit: assert property (xfer_good && stage_valid && !e_deliver |=>
		sw.sw2[0] && sw.sw2[2:1] == $past(stage_sess))
		else $error("more pending not flagged");
	a_nomem_abort: assert property (state == ST_EXEC && !kind_sus && e_sw == SW_NOMEM |=>
		!sess_active[$past(sess)] && sw == SW_NOMEM)
		else $error("6A84 left session open");
	a_rsp_tlv: assert property (state == ST_EXEC && e_deliver |=>
		rsp_buf[1] == {3'b000, $past(stage_cnt)} && rsp_len == $past(stage_cnt) + 5'h02)
		else $error("response tlv malformed");
	a_sus_reject: assert property (state == ST_EXEC && kind_sus && e_sw != SW_BAD_P1 &&
		e_sw != SW_BAD_LEN && e_sw != SW_BAD_DATA && (cond.pro_active || cond.bip_open) |=>
		sw == SW_COND && !nvm_save)
		else $error("suspend not refused with 6985");
	a_save_pulse: assert property (state == ST_EXEC && e_save |=>
		nvm_save && sw == SW_OK ##1 !nvm_save && sw.sw1 != SW1_PROACTIVE)
		else $error("suspend save sequence wrong");
	a_nego_range: assert property ($rose(nvm_save) |->
		dur_secs(nego.unit, nego.count) >= $past(min_secs) &&
		dur_secs(nego.unit, nego.count) <= $past(max_secs) && rsp_len == SUS_RSP_LEN)
		else $error("negotiated duration out of range");

	c_xfer_data: cover property (state == ST_EXEC && e_open ##1 sw.sw1 == SW1_ONGOING);
	c_deliver: cover property (state == ST_EXEC && e_deliver);
	c_suspend: cover property (state == ST_EXEC && e_save ##1 nvm_save);
	c_duration: cover property (state == ST_EXEC && e_sw == SW_DURATION);
endmodule
`default_nettype wire

// ==== tsch_terminal.sv ====
/*
 * Terminal model: apb master issuing one transfer at a time.
 * Assumes a slave on pclk that may add wait states through pready.
 */
`timescale 1ns/1ps
`default_nettype none
module tsch_terminal (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb master
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	// wait bound used up
	output logic             hang
);
	// suspend only when the descriptor allows it, no second card interface
	localparam logic SUSPEND_OK = 1'b1;

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		hang = 1'b0;
	end

	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		r = prdata;
		if (pready !== 1'b1) begin
			hang <= 1'b1;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		// released bus shows no stale value
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// ==== tsch_handler_bench.sv ====
/*
 * Self-checking bench for the transfer and suspend command handler.
 * Assumes the terminal model drives apb; read results checked from a queue.
 */
`timescale 1ns/1ps
`default_nettype none
module tsch_handler_bench;
	import tsch_pkg::*;
	typedef struct packed {
		logic        care;
		logic [32:0] val;
	} tsch_exp_t;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        nvm_save;
	logic [63:0] nvm_token;
	logic        hang;
	tsch_exp_t   exp_q[$];
	tsch_exp_t   e;
	int          errors;
	int          tests_run;
	int          saves;
	logic [31:0] seed;
	logic [31:0] r;
	logic [7:0]  cd[$];
	logic [7:0]  stg[4];
	logic [31:0] cl[4] = '{32'h02, 32'h04, 32'h08, 32'h40};

	tsch_handler DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nvm_save(nvm_save), .nvm_token(nvm_token));
	tsch_terminal term (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.hang(hang));

	always #4 pclk = ~pclk;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic end_sim;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// read results compared as they appear on the bus
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0
			&& exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e.care) begin
				check({pslverr, prdata}, e.val);
			end
		end
		if (nvm_save === 1'b1) begin
			saves++;
		end
		if (hang === 1'b1) begin
			errors++;
			end_sim();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		term.xfer(1'b1, a, d, x);
	endtask

	task automatic rd(input logic [7:0] a, input logic care, input logic [32:0] v,
		output logic [31:0] q);
		exp_q.push_back(tsch_exp_t'{care, v});
		term.xfer(1'b0, a, 32'h0, q);
	endtask

	task automatic push_rand(input int n);
		repeat (n) begin
			seed = lfsr(seed);
			cd.push_back(seed[7:0]);
		end
	endtask

	// tag stays 0x80 in every command of a session
	task automatic tlv(input int n);
		cd.push_back(TAG_SECURE);
		cd.push_back(8'(n));
		push_rand(n);
	endtask

	task automatic dur(input logic [7:0] u0, c0, u1, c1);
		cd = '{u0, c0, u1, c1};
	endtask

	task automatic cmd(input logic k, input logic [7:0] p1, input logic [7:0] le,
		input logic [15:0] sw);
		int n;
		wr(OFF_LEN, {16'h0, le, 8'(cd.size())});
		foreach (cd[i]) begin
			wr(OFF_CDATA, {24'h0, cd[i]});
		end
		wr(OFF_CTRL, {16'h0, p1, 6'h0, k, 1'b1});
		n = 0;
		r = 32'h0001_0000;
		while (r[STATUS_BUSY_BIT] !== 1'b0 && n < 8) begin
			rd(OFF_STATUS, 1'b0, 33'h0, r);
			n++;
		end
		if (r[STATUS_BUSY_BIT] !== 1'b0) begin
			errors++;
			end_sim();
		end
		rd(OFF_STATUS, 1'b1, {17'h0, sw}, r);
		cd.delete();
	endtask

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		errors = 0;
		tests_run = 0;
		saves = 0;
		seed = 32'hBA804D56;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_STATUS, 1'b1, {17'h0, SW_OK}, r);
		rd(OFF_TOKEN_LO, 1'b1, 33'h0, r);
		rd(OFF_TOKEN_HI, 1'b1, 33'h0, r);
		rd(8'h30, 1'b1, {1'b1, 32'h0}, r);
		$display("test reset done");
		for (int s = 0; s < NSESS; s++) begin
			wr(OFF_COND, {31'h0, s[0]});
			tlv(3);
			r = {16'h0, SW1_ONGOING, 4'h0, s[0], s[1:0], 1'b0};
			cmd(1'b0, {s[1:0], 6'h04}, 8'h00, r[15:0]);
		end
		wr(OFF_COND, 32'h10);
		tlv(2);
		cmd(1'b0, 8'h44, 8'h00, {SW1_ONGOING, 8'h12});
		wr(OFF_COND, 32'h0);
		cd = '{8'h81, 8'h02};
		push_rand(2);
		cmd(1'b0, 8'h04, 8'h00, SW_BAD_DATA);
		cd = '{TAG_SECURE, LEN_LONG, 8'h05};
		push_rand(5);
		cmd(1'b0, 8'h04, 8'h00, SW_BAD_DATA);
		tlv(2);
		cmd(1'b0, 8'h05, 8'h00, SW_BAD_P1);
		$display("test transfer status done");
		foreach (stg[i]) begin
			seed = lfsr(seed);
			stg[i] = seed[7:0];
			wr(OFF_STAGE, {24'h0, stg[i]});
		end
		wr(OFF_STAGE_CTL, 32'h0000_0101);
		tlv(2);
		cmd(1'b0, 8'h04, 8'h00, {SW1_ONGOING, 8'h03});
		cmd(1'b0, 8'h40, 8'h06, {SW1_ONGOING, 8'h02});
		rd(OFF_RDATA, 1'b1, {25'h0, TAG_SECURE}, r);
		rd(OFF_RDATA, 1'b1, 33'h04, r);
		foreach (stg[i]) begin
			rd(OFF_RDATA, 1'b1, {25'h0, stg[i]}, r);
		end
		rd(OFF_RDATA, 1'b1, 33'h0, r);
		// re-send of the latest response rewinds the byte pointer
		cmd(1'b0, 8'h41, 8'h06, {SW1_ONGOING, 8'h02});
		rd(OFF_RDATA, 1'b1, {25'h0, TAG_SECURE}, r);
		rd(OFF_RDATA, 1'b1, 33'h04, r);
		$display("test retrieve done");
		wr(OFF_COND, 32'h20);
		tlv(2);
		cmd(1'b0, 8'hC4, 8'h00, SW_NOMEM);
		rd(OFF_STAGE_CTL, 1'b0, 33'h0, r);
		check({32'h0, r[31]}, 33'h0);
		wr(OFF_COND, 32'h0);
		for (int s = 0; s < NSESS; s++) begin
			cmd(1'b0, {s[1:0], 6'h02}, 8'h00, SW_OK);
		end
		$display("test abort done");
		foreach (cl[i]) begin
			wr(OFF_COND, cl[i]);
			dur(8'h00, 8'h0A, 8'h01, 8'h02);
			cmd(1'b1, 8'h00, SUS_LE, SW_COND);
		end
		wr(OFF_COND, 32'h0);
		dur(CARD_LIM_UNIT, 8'h1F, UNIT_MAX, 8'h09);
		cmd(1'b1, 8'h00, SUS_LE, SW_DURATION);
		dur(8'h05, 8'h01, 8'h05, 8'h02);
		cmd(1'b1, 8'h00, SUS_LE, SW_BAD_DATA);
		dur(8'h01, 8'h05, 8'h01, 8'h02);
		cmd(1'b1, 8'h00, SUS_LE, SW_BAD_DATA);
		cd = '{8'h00, 8'h01, 8'h01};
		cmd(1'b1, 8'h00, SUS_LE, SW_BAD_LEN);
		dur(8'h00, 8'h0A, 8'h01, 8'h02);
		cmd(1'b1, 8'h00, 8'h09, SW_BAD_LEN);
		dur(8'h00, 8'h0A, 8'h01, 8'h02);
		cmd(1'b1, 8'h01, SUS_LE, SW_BAD_P1);
		dur(8'h00, 8'h0A, 8'h01, 8'h02);
		cmd(1'b1, 8'h02, SUS_LE, SW_BAD_P1);
		check(33'(saves), 33'h0);
		$display("test suspend refusal done");
		dur(8'h00, 8'h0A, 8'h01, 8'h02);
		cmd(1'b1, 8'h00, SUS_LE, SW_OK);
		check(33'(saves), 33'h1);
		rd(OFF_NEGO, 1'b1, {12'h0, SUS_RSP_LEN, 8'h01, 8'h02}, r);
		rd(OFF_RDATA, 1'b1, 33'h01, r);
		rd(OFF_RDATA, 1'b1, 33'h02, r);
		for (int i = 0; i < TOKEN_BYTES; i++) begin
			rd(OFF_RDATA, 1'b0, 33'h0, r);
			check({25'h0, r[7:0]}, {25'h0, nvm_token[63 - 8 * i -: 8]});
		end
		rd(OFF_TOKEN_LO, 1'b0, 33'h0, r);
		check({1'b0, r}, {1'b0, nvm_token[31:0]});
		$display("test suspend done");
		// contacts deactivated after the good suspend, then a fresh start
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_STATUS, 1'b1, {17'h0, SW_OK}, r);
		rd(OFF_TOKEN_HI, 1'b1, 33'h0, r);
		rd(OFF_STAGE_CTL, 1'b1, 33'h0, r);
		$display("test deactivation done");
		end_sim();
	end
endmodule
`default_nettype wire
